/* dem_checker.sv */
`timescale 1ns/100ps
module dem_checker (
	// clock and reset
	input wire logic               clk_sys,
	input wire logic               rstn,
	// interface
	input wire logic               req,
	input wire dem_pkg::dem_kind_t kind,
	input wire logic               we,
	input wire logic [15:0]        addr,
	input wire logic [7:0]         rdata,
	input wire logic               rvalid,
	// off-chip strobes
	input wire logic               ext_rd,
	input wire logic               ext_wr
);
	localparam dem_pkg::dem_kind_t XD = dem_pkg::DEM_KIND_XDATA;
	localparam dem_pkg::dem_kind_t DR = dem_pkg::DEM_KIND_DIRECT;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	property p_int_rd; req && !we && kind != XD |=> rvalid; endproperty
	a_int_rd: assert property (p_int_rd) else $error("internal read unanswered");
	property p_int_quiet; req && kind != XD |=> !ext_rd && !ext_wr; endproperty
	a_int_quiet: assert property (p_int_quiet) else $error("internal move went off-chip");
	property p_wr_quiet; req && we |=> !rvalid; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("write gave read answer");
	property p_ext_rd; ext_rd |=> !rvalid ##1 rvalid; endproperty
	a_ext_rd: assert property (p_ext_rd) else $error("off-chip read answer late");
	property p_ext_cause; ext_rd |-> $past(req && !we && kind == XD); endproperty
	a_ext_cause: assert property (p_ext_cause) else $error("off-chip read without move");
	property p_ext_wr; ext_wr |-> $past(req && we && kind == XD); endproperty
	a_ext_wr: assert property (p_ext_wr) else $error("off-chip write without move");
	property p_ctl_top;
		req && !we && kind == DR && addr[7:0] == dem_pkg::SFR_MEMCTL |=> rdata[7:6] == 2'b00;
	endproperty
	a_ctl_top: assert property (p_ctl_top) else $error("control top bits not zero");
	property p_sfr_gap; req && !we && kind == DR && addr[7:0] == 8'ha0 |=> rdata == 8'h00; endproperty
	a_sfr_gap: assert property (p_sfr_gap) else $error("direct a0 read not sfr space");
	c_ext_rd: cover property (ext_rd);
	c_ext_wr: cover property (ext_wr);
	c_ctl_rd: cover property (req && kind == DR && addr[7:0] == dem_pkg::SFR_MEMCTL);
endmodule

/* dem_dev.sv */
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
module dem_dev #(
	parameter int unsigned PROG_CYCLES = dem_pkg::PROG_CYCLES
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// cpu side
	dem_if.dev               bus,
	// off-chip data bus
	output logic             ext_rd,
	output logic             ext_wr,
	output logic [15:0]      ext_addr,
	output logic [7:0]       ext_wdata,
	input  wire logic [7:0]  ext_rdata,
	// supply good, asynchronous
	input  wire logic        vcc_ok
);
	typedef struct packed {
		logic                                  vcc_s1;
		logic                                  vcc_s2;
		logic                                  page_load;
		logic                                  wr_en;
		logic                                  ee_sel;
		logic                                  ptr_sel;
		logic [dem_pkg::PTR_W-1:0]             ptr0;
		logic [dem_pkg::PTR_W-1:0]             ptr1;
		dem_pkg::dem_prog_t                    prog;
		dem_pkg::dem_cnt_t                     timer;
		logic [5:0]                            page;
		logic [dem_pkg::PAGE_BYTES-1:0]        mask;
		logic [dem_pkg::PAGE_BYTES-1:0][7:0]   wbuf;
		logic [7:0]                            last;
		logic                                  ext_pend;
		logic                                  ext_cap;
		logic [7:0]                            rdata;
		logic                                  rvalid;
		logic                                  ext_rd;
		logic                                  ext_wr;
		logic [15:0]                           ext_addr;
		logic [7:0]                            ext_wdata;
		logic [dem_pkg::RAM_BYTES-1:0][7:0]    ram;
		logic [dem_pkg::EE_BYTES-1:0][7:0]     ee;
	} dem_dev_state_t;

	dem_dev_state_t             s_reg;
	dem_dev_state_t             s_next;
	logic [dem_pkg::PTR_W-1:0]  ptr;
	logic                       on_chip;
	logic [7:0]                 ctl_rd;
	logic [dem_pkg::PAGE_AW-1:0] slot;
	logic [dem_pkg::EE_AW-dem_pkg::PAGE_AW-1:0] page_idx;

	// selected pointer and eeprom decode
	assign ptr     = s_reg.ptr_sel ? s_reg.ptr1 : s_reg.ptr0;
	assign on_chip = s_reg.ee_sel && (ptr[15:dem_pkg::EE_AW] == '0);
	assign slot    = ptr[dem_pkg::PAGE_AW-1:0];
	assign page_idx = ptr[dem_pkg::EE_AW-1:dem_pkg::PAGE_AW];

	// control register read view
	always_comb begin
		ctl_rd = dem_pkg::BYTE_ZERO;
		ctl_rd[dem_pkg::BIT_PAGE_LOAD] = s_reg.page_load;
		ctl_rd[dem_pkg::BIT_WR_EN]     = s_reg.wr_en;
		ctl_rd[dem_pkg::BIT_EE_SEL]    = s_reg.ee_sel;
		ctl_rd[dem_pkg::BIT_PTR_SEL]   = s_reg.ptr_sel;
		ctl_rd[dem_pkg::BIT_READY]     = (s_reg.prog == dem_pkg::DEM_PROG_IDLE);
		ctl_rd[dem_pkg::BIT_WR_INH]    = s_reg.vcc_s2;
	end

	always_comb begin
		s_next = s_reg;
		s_next.rvalid  = 1'b0;
		s_next.ext_rd  = 1'b0;
		s_next.ext_wr  = 1'b0;
		s_next.ext_cap = s_reg.ext_rd;
		s_next.vcc_s1  = vcc_ok;
		s_next.vcc_s2  = s_reg.vcc_s1;

		// off-chip read data, one cycle after the strobe
		if (s_reg.ext_cap) begin
			s_next.rdata    = ext_rdata;
			s_next.rvalid   = 1'b1;
			s_next.ext_pend = 1'b0;
		end

		// programming cycle timer
		if (s_reg.prog == dem_pkg::DEM_PROG_BUSY) begin
			if (!s_reg.vcc_s2) begin
				s_next.prog = dem_pkg::DEM_PROG_IDLE;
				s_next.mask = '0;
			end else if (s_reg.timer > dem_pkg::dem_cnt_t'(1)) begin
				s_next.timer = s_reg.timer - dem_pkg::dem_cnt_t'(1);
			end else begin
				// only loaded bytes of the page are rewritten
				for (int i = 0; i < dem_pkg::PAGE_BYTES; i++) begin
					if (s_reg.mask[i]) begin
						s_next.ee[{s_reg.page, 5'(i)}] = s_reg.wbuf[i];
					end
				end
				s_next.mask  = '0;
				s_next.timer = '0;
				s_next.prog  = dem_pkg::DEM_PROG_IDLE;
			end
		end

		if (bus.req && !s_reg.ext_pend) begin
			case (bus.kind)
				dem_pkg::DEM_KIND_DIRECT: begin
					if (bus.addr[7:0] >= dem_pkg::SFR_BASE) begin
						// direct addressing above 7fh is sfr space
						if (bus.we) begin
							case (bus.addr[7:0])
								dem_pkg::SFR_PTR0_L: s_next.ptr0[7:0]  = bus.wdata;
								dem_pkg::SFR_PTR0_H: s_next.ptr0[15:8] = bus.wdata;
								dem_pkg::SFR_PTR1_L: s_next.ptr1[7:0]  = bus.wdata;
								dem_pkg::SFR_PTR1_H: s_next.ptr1[15:8] = bus.wdata;
								dem_pkg::SFR_MEMCTL: begin
									s_next.page_load = bus.wdata[dem_pkg::BIT_PAGE_LOAD];
									s_next.wr_en     = bus.wdata[dem_pkg::BIT_WR_EN];
									s_next.ee_sel    = bus.wdata[dem_pkg::BIT_EE_SEL];
									s_next.ptr_sel   = bus.wdata[dem_pkg::BIT_PTR_SEL];
								end
								default: begin
								end
							endcase
						end else begin
							s_next.rvalid = 1'b1;
							case (bus.addr[7:0])
								dem_pkg::SFR_PTR0_L: s_next.rdata = s_reg.ptr0[7:0];
								dem_pkg::SFR_PTR0_H: s_next.rdata = s_reg.ptr0[15:8];
								dem_pkg::SFR_PTR1_L: s_next.rdata = s_reg.ptr1[7:0];
								dem_pkg::SFR_PTR1_H: s_next.rdata = s_reg.ptr1[15:8];
								dem_pkg::SFR_MEMCTL: s_next.rdata = ctl_rd;
								default:             s_next.rdata = dem_pkg::BYTE_ZERO;
							endcase
						end
					end else begin
						// lower ram
						if (bus.we) begin
							s_next.ram[bus.addr[7:0]] = bus.wdata;
						end else begin
							s_next.rdata  = s_reg.ram[bus.addr[7:0]];
							s_next.rvalid = 1'b1;
						end
					end
				end
				dem_pkg::DEM_KIND_INDIRECT: begin
					// indirect reaches all 256 bytes, upper half separate from sfr
					if (bus.we) begin
						s_next.ram[bus.addr[7:0]] = bus.wdata;
					end else begin
						s_next.rdata  = s_reg.ram[bus.addr[7:0]];
						s_next.rvalid = 1'b1;
					end
				end
				dem_pkg::DEM_KIND_XDATA: begin
					if (on_chip) begin
						if (bus.we) begin
							// ignored unless enabled and idle
							if (s_reg.wr_en && (s_reg.prog == dem_pkg::DEM_PROG_IDLE)) begin
								s_next.mask = (s_reg.page == page_idx) ? s_reg.mask : '0;
								s_next.mask[slot] = 1'b1;
								s_next.wbuf[slot] = bus.wdata;
								s_next.page       = page_idx;
								s_next.last       = bus.wdata;
								// page load only fills the buffer
								if (!s_reg.page_load && s_reg.vcc_s2) begin
									s_next.prog  = dem_pkg::DEM_PROG_BUSY;
									s_next.timer = dem_pkg::dem_cnt_t'(PROG_CYCLES);
								end
							end
						end else begin
							s_next.rvalid = 1'b1;
							if (s_reg.prog == dem_pkg::DEM_PROG_BUSY) begin
								s_next.rdata = s_reg.last ^ dem_pkg::MSB_FLIP;
							end else begin
								s_next.rdata = s_reg.ee[ptr[dem_pkg::EE_AW-1:0]];
							end
						end
					end else begin
						// off-chip data memory
						s_next.ext_addr = ptr;
						if (bus.we) begin
							s_next.ext_wr    = 1'b1;
							s_next.ext_wdata = bus.wdata;
						end else begin
							s_next.ext_rd   = 1'b1;
							s_next.ext_pend = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_reg           <= '0;
			s_reg.vcc_s1    <= 1'b1;
			s_reg.vcc_s2    <= 1'b1;
			s_reg.ptr0      <= dem_pkg::PTR_RESET;
			s_reg.ptr1      <= dem_pkg::PTR_RESET;
			s_reg.prog      <= dem_pkg::DEM_PROG_IDLE;
			s_reg.ee        <= {dem_pkg::EE_BYTES{dem_pkg::EE_ERASED}};
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs
	assign bus.rdata  = s_reg.rdata;
	assign bus.rvalid = s_reg.rvalid;
	assign ext_rd     = s_reg.ext_rd;
	assign ext_wr     = s_reg.ext_wr;
	assign ext_addr   = s_reg.ext_addr;
	assign ext_wdata  = s_reg.ext_wdata;
endmodule

/* dem_host.sv */
`timescale 1ns/100ps
module dem_host (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	// device side
	dem_if.cpu                       bus,
	// command port
	input  wire logic                cmd_valid,
	input  wire dem_pkg::dem_kind_t  cmd_kind,
	input  wire logic                cmd_we,
	input  wire logic [15:0]         cmd_addr,
	input  wire logic [7:0]          cmd_wdata,
	output logic                     cmd_ready,
	// read answers
	output logic                     rsp_valid,
	output logic [7:0]               rsp_data
);
	typedef struct packed {
		dem_pkg::dem_host_t  state;
		logic                req;
		dem_pkg::dem_kind_t  kind;
		logic                we;
		logic [15:0]         addr;
		logic [7:0]          wdata;
		logic                rsp_valid;
		logic [7:0]          rsp_data;
	} dem_host_state_t;

	dem_host_state_t  s_reg;
	dem_host_state_t  s_next;

	always_comb begin
		s_next = s_reg;
		s_next.req       = 1'b0;
		s_next.rsp_valid = 1'b0;
		case (s_reg.state)
			dem_pkg::DEM_HOST_IDLE: begin
				if (cmd_valid) begin
					// one move at a time; writes need no answer
					s_next.req   = 1'b1;
					s_next.kind  = cmd_kind;
					s_next.we    = cmd_we;
					s_next.addr  = cmd_addr;
					s_next.wdata = cmd_wdata;
					if (!cmd_we) begin
						s_next.state = dem_pkg::DEM_HOST_WAIT;
					end
				end
			end
			dem_pkg::DEM_HOST_WAIT: begin
				if (bus.rvalid) begin
					s_next.rsp_valid = 1'b1;
					s_next.rsp_data  = bus.rdata;
					s_next.state     = dem_pkg::DEM_HOST_IDLE;
				end
			end
			default: begin
				s_next.state = dem_pkg::DEM_HOST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_reg       <= '0;
			s_reg.state <= dem_pkg::DEM_HOST_IDLE;
			s_reg.kind  <= dem_pkg::DEM_KIND_DIRECT;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cmd_ready = (s_reg.state == dem_pkg::DEM_HOST_IDLE);
	assign bus.req   = s_reg.req;
	assign bus.kind  = s_reg.kind;
	assign bus.we    = s_reg.we;
	assign bus.addr  = s_reg.addr;
	assign bus.wdata = s_reg.wdata;
	assign rsp_valid = s_reg.rsp_valid;
	assign rsp_data  = s_reg.rsp_data;
endmodule

/* dem_if.sv */
`timescale 1ns/100ps
interface dem_if;
	logic                 req;
	dem_pkg::dem_kind_t   kind;
	logic                 we;
	logic [15:0]          addr;
	logic [7:0]           wdata;
	logic [7:0]           rdata;
	logic                 rvalid;

	modport dev (
		input  req,
		input  kind,
		input  we,
		input  addr,
		input  wdata,
		output rdata,
		output rvalid
	);

	modport cpu (
		output req,
		output kind,
		output we,
		output addr,
		output wdata,
		input  rdata,
		input  rvalid
	);
endinterface

/* dem_pkg.sv */
package dem_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned PROG_TIME_MS  = 4;
	localparam int unsigned PROG_CYCLES   = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W         = 20;
	localparam int unsigned EE_BYTES      = 2048;
	localparam int unsigned EE_AW         = 11;
	localparam int unsigned RAM_BYTES     = 256;
	localparam int unsigned PAGE_BYTES    = 32;
	localparam int unsigned PAGE_AW       = 5;
	localparam int unsigned PTR_W         = 16;

	localparam logic [7:0] SFR_BASE   = 8'h80;
	localparam logic [7:0] SFR_PTR0_L = 8'h82;
	localparam logic [7:0] SFR_PTR0_H = 8'h83;
	localparam logic [7:0] SFR_PTR1_L = 8'h84;
	localparam logic [7:0] SFR_PTR1_H = 8'h85;
	localparam logic [7:0] SFR_MEMCTL = 8'h96;

	localparam int unsigned BIT_PAGE_LOAD = 5;
	localparam int unsigned BIT_WR_EN     = 4;
	localparam int unsigned BIT_EE_SEL    = 3;
	localparam int unsigned BIT_PTR_SEL   = 2;
	localparam int unsigned BIT_READY     = 1;
	localparam int unsigned BIT_WR_INH    = 0;

	localparam logic [7:0]       MSB_FLIP   = 8'h80;
	localparam logic [7:0]       EE_ERASED  = 8'hff;
	localparam logic [7:0]       BYTE_ZERO  = 8'h00;
	localparam logic [PTR_W-1:0] PTR_RESET  = 16'h0000;

	typedef logic [CNT_W-1:0] dem_cnt_t;

	typedef enum logic [1:0] {
		DEM_KIND_DIRECT   = 2'h0,
		DEM_KIND_INDIRECT = 2'h1,
		DEM_KIND_XDATA    = 2'h3
	} dem_kind_t;

	typedef enum logic {
		DEM_PROG_IDLE = 1'b0,
		DEM_PROG_BUSY = 1'b1
	} dem_prog_t;

	typedef enum logic {
		DEM_HOST_IDLE = 1'b0,
		DEM_HOST_WAIT = 1'b1
	} dem_host_t;
endpackage

/* tb_data_eeprom_access.sv */
`timescale 1ns/100ps
module tb_data_eeprom_access;
	localparam int                 PC = 20;
	localparam dem_pkg::dem_kind_t D = dem_pkg::DEM_KIND_DIRECT;
	localparam dem_pkg::dem_kind_t I = dem_pkg::DEM_KIND_INDIRECT;
	localparam dem_pkg::dem_kind_t X = dem_pkg::DEM_KIND_XDATA;
	logic               clk_sys = 1'b0;
	logic               rstn = 1'b0;
	logic               vcc_ok = 1'b1;
	logic               cmd_valid = 1'b0;
	logic               cmd_we = 1'b0;
	dem_pkg::dem_kind_t cmd_kind = dem_pkg::DEM_KIND_DIRECT;
	logic [15:0]        cmd_addr = 16'h0;
	logic [7:0]         cmd_wdata = 8'h0;
	logic [7:0]         ext_rdata = 8'h0;
	logic               cmd_ready, rsp_valid, ext_rd, ext_wr;
	logic [15:0]        ext_addr;
	logic [7:0]         rsp_data, ext_wdata, x;
	logic [7:0]         v [4];
	int                 errors = 0;
	int                 comparisons = 0;
	int                 c;
	int                 n_rd = 0;
	int                 n_wr = 0;
	dem_if i_dem_if ();
	dem_host i_dem_host (.clk_sys, .rstn, .bus(i_dem_if.cpu), .cmd_valid, .cmd_kind, .cmd_we,
		.cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_data);
	dem_dev #(.PROG_CYCLES(PC)) i_dem_dev (.clk_sys, .rstn, .bus(i_dem_if.dev), .ext_rd, .ext_wr,
		.ext_addr, .ext_wdata, .ext_rdata, .vcc_ok);
	dem_checker i_dem_checker (.clk_sys, .rstn, .req(i_dem_if.req), .kind(i_dem_if.kind),
		.we(i_dem_if.we), .addr(i_dem_if.addr), .rdata(i_dem_if.rdata),
		.rvalid(i_dem_if.rvalid), .ext_rd, .ext_wr);
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// off-chip byte pattern
	function automatic logic [7:0] ext_byte(logic [15:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction
	// off-chip memory answers next cycle, else keeps toggling; strobes counted
	always @(posedge clk_sys) begin
		ext_rdata <= ext_rd ? ext_byte(ext_addr) : ~ext_rdata;
		n_rd      <= n_rd + int'(ext_rd === 1'b1);
		n_wr      <= n_wr + int'(ext_wr === 1'b1);
	end
	task automatic stop_test();
		if (errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic op(dem_pkg::dem_kind_t k, logic w, logic [15:0] a, logic [7:0] d);
		int n;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_we <= w;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		#1;
		chk("cmd ready", 8'(cmd_ready), 8'(w));
		n = 0;
		while (!w && rsp_valid !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n == 20) begin
			errors++;
			stop_test();
		end
	endtask
	task automatic rc(string s, dem_pkg::dem_kind_t k, logic [15:0] a, logic [7:0] e);
		op(k, 1'b0, a, 8'h0);
		chk(s, rsp_data, e);
	endtask
	task automatic ptr(logic b, logic [15:0] p);
		op(D, 1'b1, b ? 16'h84 : 16'h82, p[7:0]);
		op(D, 1'b1, b ? 16'h85 : 16'h83, p[15:8]);
	endtask
	// polls ready, returns cycles spent
	task automatic poll(output int n);
		time t0;
		t0 = $time;
		n = 0;
		do begin
			op(D, 1'b0, 16'h96, 8'h0);
			n++;
		end while (rsp_data[1] !== 1'b1 && n < 50);
		if (n == 50) begin
			errors++;
			stop_test();
		end
		n = int'(($time - t0) / 10);
	endtask
	initial begin
		c = $urandom(32'hd3f337df);
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rc("control", D, 16'h96, 8'h03);
		op(D, 1'b1, 16'h96, 8'hc0);
		rc("control top", D, 16'h96, 8'h03);
		for (int i = 0; i < 4; i++) begin
			v[i] = 8'($urandom);
			op(D, 1'b1, 16'h82 + 16'(i), v[i]);
		end
		for (int i = 0; i < 4; i++) begin
			rc("pointer", D, 16'h82 + 16'(i), v[i]);
		end
		x = 8'($urandom);
		op(I, 1'b1, 16'ha0, x);
		rc("sfr a0", D, 16'ha0, 8'h00);
		rc("upper ram", I, 16'ha0, x);
		op(D, 1'b1, 16'h10, ~x);
		rc("lower ram", I, 16'h10, ~x);
		op(D, 1'b1, 16'h96, 8'h00);
		ptr(1'b0, 16'h0123);
		rc("off-chip read", X, 16'h0, ext_byte(16'h0123));
		op(X, 1'b1, 16'h0, x);
		repeat (3) @(posedge clk_sys);
		chk("off-chip addr", ext_addr[7:0], 8'h23);
		chk("off-chip data", ext_wdata, x);
		op(D, 1'b1, 16'h96, 8'h0c);
		ptr(1'b1, 16'h0800);
		rc("beyond 2k", X, 16'h0, ext_byte(16'h0800));
		chk("off-chip reads", 8'(n_rd), 8'h02);
		op(D, 1'b1, 16'h96, 8'h08);
		rc("eeprom blank", X, 16'h0, 8'hff);
		op(X, 1'b1, 16'h0, x);
		rc("ready kept", D, 16'h96, 8'h0b);
		rc("no write", X, 16'h0, 8'hff);
		op(D, 1'b1, 16'h96, 8'h18);
		op(X, 1'b1, 16'h0, x);
		rc("ready low", D, 16'h96, 8'h19);
		rc("busy read", X, 16'h0, x ^ 8'h80);
		poll(c);
		rc("byte stored", X, 16'h0, x);
		ptr(1'b0, 16'h0124);
		rc("neighbour", X, 16'h0, 8'hff);
		op(D, 1'b1, 16'h96, 8'h38);
		for (int i = 0; i < 4; i++) begin
			ptr(1'b0, 16'h0140 + 16'(i));
			op(X, 1'b1, 16'h0, v[i]);
		end
		rc("load only", D, 16'h96, 8'h3b);
		rc("not programmed", X, 16'h0, 8'hff);
		op(D, 1'b1, 16'h96, 8'h18);
		ptr(1'b0, 16'h0144);
		op(X, 1'b1, 16'h0, x);
		poll(c);
		chk("page time", 8'(c >= PC && c < PC + 16), 8'h01);
		for (int i = 0; i < 4; i++) begin
			ptr(1'b0, 16'h0140 + 16'(i));
			rc("page byte", X, 16'h0, v[i]);
		end
		ptr(1'b0, 16'h0123);
		op(X, 1'b1, 16'h0, ~x);
		@(posedge clk_sys);
		vcc_ok <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rc("low supply", D, 16'h96, 8'h1a);
		op(X, 1'b1, 16'h0, ~x);
		rc("inhibited", D, 16'h96, 8'h1a);
		@(posedge clk_sys);
		vcc_ok <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rc("aborted", X, 16'h0, x);
		op(D, 1'b1, 16'h96, 8'h08);
		chk("off-chip writes", 8'(n_wr), 8'h01);
		chk("off-chip reads", 8'(n_rd), 8'h02);
		stop_test();
	end
endmodule
